// ===== design/nvsc_host.sv
`timescale 1ns/1ns
`default_nettype none
`include "nvsc_params.svh"
// Function
// [R01] keep store-busy released high during every ordinary read or write
// [R02] upper-lane-only access: device uses upper lane, lower lanes float
// [R03] lower-lane-only access: device uses lower lane, upper lanes float
// [R04] lane enables only matter in word-wide organisation
// [R05] command sequence is issued as chip-enable framed read cycles
// [R06] six command addresses read back to back, no other access between
// [R07] write enable held high through all six command reads
// [R08] data of the sixth command read is discarded as invalid
// [R09] device acts on a finished command within 100 us
// [R10] no access while commanded save or restore runs
// [R11] array access blocked while host drives store-busy low
// [R12] device skips hardware save when nothing written since last one
// [R13] no write pending: outputs return within 25 ns of request
// [R14] store-busy not driven by device when idle, weak pull-up only
// [R15] device ignores accesses during non-volatile operation
// [R16] in-flight write may complete for 25 ns after save request
module nvsc_host
  import nvsc_pkg::*;
#(
  parameter logic [`NVSC_ADDR_W*6-1:0] SEQ_TABLE = '0,
  parameter int unsigned CYC_SS    = `NVSC_CYC_SS,
  parameter int unsigned CYC_STORE = `NVSC_CYC_STORE
)(
  // clock and reset
  input  wire logic                    REF_CLK_I,
  input  wire logic                    ARST_N_I,
  // command port
  input  wire logic                    CMD_VALID_I,
  input  wire logic [1:0]              CMD_KIND_I,
  input  wire logic [`NVSC_ADDR_W-1:0] CMD_ADDR_I,
  input  wire logic [`NVSC_DATA_W-1:0] CMD_WDATA_I,
  input  wire logic [1:0]              CMD_LANES_I,
  input  wire logic                    WIDE_MODE_I,
  output logic                         CMD_READY_O,
  output logic                         RSP_VALID_O,
  output logic [`NVSC_DATA_W-1:0]      RSP_RDATA_O,
  // memory pins
  output logic [`NVSC_ADDR_W-1:0]      MEM_ADDR_O,
  output logic                         CHIP_EN_N_O,
  output logic                         WRITE_EN_N_O,
  output logic                         OUT_EN_N_O,
  output logic                         UPPER_LANE_ENABLE_N_O,
  output logic                         LOWER_LANE_ENABLE_N_O,
  input  wire logic [`NVSC_DATA_W-1:0] MEM_DQ_I,
  output logic [`NVSC_DATA_W-1:0]      MEM_DQ_O,
  output logic                         MEM_DQ_OE_O,
  // store-busy open-drain pin
  input  wire logic                    STORE_BUSY_N_I,
  output logic                         STORE_BUSY_N_O,
  output logic                         STORE_BUSY_N_OE_O
);
  ////////////////////////////////////////////////////////////////////////
  logic [`NVSC_DATA_W-1:0] dq_s1_q, dq_s2_q;
  logic                    sb_s1_q, sb_s2_q;

  // two-flop synchronisers on pins from the device
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
      sb_s1_q <= 1'b1;
      sb_s2_q <= 1'b1;
    end else begin
      dq_s1_q <= MEM_DQ_I;
      dq_s2_q <= dq_s1_q;
      sb_s1_q <= STORE_BUSY_N_I;
      sb_s2_q <= sb_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  nvsc_state_e             st_q, st_d;
  logic [`NVSC_CNT_W-1:0]  cnt_q, cnt_d;
  logic [2:0]              seq_q, seq_d;
  logic [1:0]              kind_q, kind_d;
  logic [`NVSC_ADDR_W-1:0] addr_q, addr_d;
  logic [`NVSC_DATA_W-1:0] wdat_q, wdat_d, rdat_q, rdat_d;
  logic [1:0]              lanes_q, lanes_d;
  logic                    ce_q, ce_d, we_q, we_d, oe_q, oe_d;
  logic                    ub_q, ub_d, lb_q, lb_d, dqoe_q, dqoe_d;
  logic                    rdy_q, rdy_d, rv_q, rv_d, sbd_q, sbd_d;
  logic [`NVSC_ADDR_W-1:0] seq_addr;

  // command addresses, looked up one cycle ahead of use
  nvsc_seq_rom u_rom (
    .clk_i   (REF_CLK_I),
    .idx_i   (seq_d),
    .table_i (SEQ_TABLE),
    .addr_o  (seq_addr)
  );

  // access sequencer: next-state logic
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    seq_d   = seq_q;
    kind_d  = kind_q;
    addr_d  = addr_q;
    wdat_d  = wdat_q;
    rdat_d  = rdat_q;
    lanes_d = lanes_q;
    ce_d    = ce_q;
    we_d    = we_q;
    oe_d    = oe_q;
    ub_d    = ub_q;
    lb_d    = lb_q;
    dqoe_d  = dqoe_q;
    rdy_d   = 1'b0;
    rv_d    = 1'b0;
    sbd_d   = 1'b0;                             // R01
    case (st_q)
      NVSC_IDLE: begin
        rdy_d = 1'b1;
        if (CMD_VALID_I && rdy_q) begin
          rdy_d   = 1'b0;
          kind_d  = CMD_KIND_I;
          addr_d  = CMD_ADDR_I;
          wdat_d  = CMD_WDATA_I;
          // byte-wide part: both lanes always on
          lanes_d = WIDE_MODE_I ? CMD_LANES_I : 2'h3;    // R04
          seq_d   = 3'h0;
          cnt_d   = '0;
          st_d    = (CMD_KIND_I == `NVSC_CMD_HWSAVE) ? NVSC_HWREQ : NVSC_SETUP;
        end
      end
      NVSC_SETUP: begin
        ce_d   = 1'b0;
        ub_d   = ~lanes_q[1];                   // R02
        lb_d   = ~lanes_q[0];                   // R03
        we_d   = ~(kind_q == `NVSC_CMD_WRITE);  // R07
        oe_d   = (kind_q == `NVSC_CMD_WRITE);   // R05
        dqoe_d = (kind_q == `NVSC_CMD_WRITE);
        if (kind_q == `NVSC_CMD_SOFT) begin
          addr_d = seq_addr;                    // R06
          ub_d   = 1'b0;
          lb_d   = 1'b0;
        end
        cnt_d = '0;
        st_d  = NVSC_STROBE;
      end
      NVSC_STROBE: begin
        cnt_d = cnt_q + 1'b1;
        // rc covers pwe, so one count serves both cycle kinds
        if (cnt_q == `NVSC_CNT_W'(`NVSC_CYC_RC + 2)) begin
          rdat_d = dq_s2_q;
          ce_d   = 1'b1;
          we_d   = 1'b1;
          oe_d   = 1'b1;
          st_d   = NVSC_HOLD;
        end
      end
      NVSC_HOLD: begin
        ub_d   = 1'b1;
        lb_d   = 1'b1;
        dqoe_d = 1'b0;
        cnt_d  = '0;
        if (kind_q == `NVSC_CMD_SOFT) begin
          // back to back, nothing else accepted in between
          if (seq_q == 3'(`NVSC_SEQ_LEN - 1)) begin   // R06
            rdat_d = '0;                        // R08
            st_d   = NVSC_WAIT;
          end else begin
            seq_d = seq_q + 3'h1;
            st_d  = NVSC_SETUP;
          end
        end else begin
          rv_d = 1'b1;
          st_d = NVSC_IDLE;
        end
      end
      NVSC_HWREQ: begin
        // drive store-busy low for the pulse width
        sbd_d = 1'b1;                           // R11
        cnt_d = cnt_q + 1'b1;
        // held for the full rounded-up count, so the pulse is never short
        if (cnt_q == `NVSC_CNT_W'(`NVSC_CYC_PHSB)) begin
          sbd_d = 1'b0;
          cnt_d = '0;
          st_d  = NVSC_WAIT;
        end
      end
      NVSC_WAIT: begin
        // soft command: worst-case wait, processing plus store; hardware save waits for busy high instead
        cnt_d = cnt_q + 1'b1;                   // R09
        if (kind_q == `NVSC_CMD_HWSAVE) begin
          // synchronised busy high after the release window ends it
          if (cnt_q > `NVSC_CNT_W'(`NVSC_CYC_DLY + 2) && sb_s2_q) begin  // R12 R13 R14 R16
            rv_d = 1'b1;
            st_d = NVSC_IDLE;
          end
        end else if (cnt_q == `NVSC_CNT_W'(CYC_SS + CYC_STORE)) begin  // R10 R15
          rv_d = 1'b1;
          st_d = NVSC_IDLE;
        end
      end
      default: st_d = NVSC_IDLE;
    endcase
  end

  // sequencer registers
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_q    <= NVSC_IDLE;
      cnt_q   <= '0;
      seq_q   <= 3'h0;
      kind_q  <= `NVSC_CMD_READ;
      addr_q  <= '0;
      wdat_q  <= '0;
      rdat_q  <= '0;
      lanes_q <= 2'h3;
      ce_q    <= 1'b1;
      we_q    <= 1'b1;
      oe_q    <= 1'b1;
      ub_q    <= 1'b1;
      lb_q    <= 1'b1;
      dqoe_q  <= 1'b0;
      rdy_q   <= 1'b0;
      rv_q    <= 1'b0;
      sbd_q   <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      seq_q   <= seq_d;
      kind_q  <= kind_d;
      addr_q  <= addr_d;
      wdat_q  <= wdat_d;
      rdat_q  <= rdat_d;
      lanes_q <= lanes_d;
      ce_q    <= ce_d;
      we_q    <= we_d;
      oe_q    <= oe_d;
      ub_q    <= ub_d;
      lb_q    <= lb_d;
      dqoe_q  <= dqoe_d;
      rdy_q   <= rdy_d;
      rv_q    <= rv_d;
      sbd_q   <= sbd_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // all outputs but STORE_BUSY_N_O straight from flops
  assign CMD_READY_O           = rdy_q;
  assign RSP_VALID_O           = rv_q;
  assign RSP_RDATA_O           = rdat_q;
  assign MEM_ADDR_O            = addr_q;
  assign CHIP_EN_N_O           = ce_q;
  assign WRITE_EN_N_O          = we_q;
  assign OUT_EN_N_O            = oe_q;
  assign UPPER_LANE_ENABLE_N_O = ub_q;
  assign LOWER_LANE_ENABLE_N_O = lb_q;
  assign MEM_DQ_O              = wdat_q;
  assign MEM_DQ_OE_O           = dqoe_q;
  // open drain: only ever pull low
  assign STORE_BUSY_N_O        = 1'b0;
  assign STORE_BUSY_N_OE_O     = sbd_q;
endmodule : nvsc_host
`default_nettype wire

// ===== design/nvsc_params.svh
`ifndef NVSC_PARAMS_SVH
`define NVSC_PARAMS_SVH
// clock period in ns
`define NVSC_CLK_NS        4
// pin widths
`define NVSC_ADDR_W        17
`define NVSC_DATA_W        16
// read/write cycle time and write pulse width (25 ns grade)
`define NVSC_T_RC_NS       25
`define NVSC_T_PWE_NS      20
// hardware save request pulse width
`define NVSC_HW_SAVE_REQUEST_PULSE_NS     15
// release time of outputs when no write is pending
`define NVSC_IDLE_RELEASE_TIME_NS     25
// in-flight write completion window after a save request
`define NVSC_T_DELAY_NS    25
// soft sequence processing time, us
`define NVSC_T_SS_US       100
// longest non-volatile operation (store) in ms
`define NVSC_T_STORE_MS    8
// derived counts: least times round up
`define NVSC_CYC_RC    ((`NVSC_T_RC_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_CYC_PWE   ((`NVSC_T_PWE_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_CYC_PHSB  ((`NVSC_HW_SAVE_REQUEST_PULSE_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_CYC_DLY   ((`NVSC_T_DELAY_NS + `NVSC_CLK_NS - 1) / `NVSC_CLK_NS)
`define NVSC_CYC_SS    ((`NVSC_T_SS_US * 1000) / `NVSC_CLK_NS)
`define NVSC_CYC_STORE ((`NVSC_T_STORE_MS * 1000000) / `NVSC_CLK_NS)
// counter width
`define NVSC_CNT_W         22
// number of command reads
`define NVSC_SEQ_LEN       6
// command kinds
`define NVSC_CMD_READ      2'h0
`define NVSC_CMD_WRITE     2'h1
`define NVSC_CMD_SOFT      2'h2
`define NVSC_CMD_HWSAVE    2'h3
`endif

// ===== design/nvsc_pkg.sv
`default_nettype none
package nvsc_pkg;
  // controller states, gray along idle->setup->strobe->hold->idle
  typedef enum logic [2:0] {
    NVSC_IDLE   = 3'h0,
    NVSC_SETUP  = 3'h1,
    NVSC_STROBE = 3'h3,
    NVSC_HOLD   = 3'h2,
    NVSC_HWREQ  = 3'h6,
    NVSC_WAIT   = 3'h7
  } nvsc_state_e;
endpackage : nvsc_pkg
`default_nettype wire

// ===== design/nvsc_seq_rom.sv
`timescale 1ns/1ns
`default_nettype none
`include "nvsc_params.svh"
// command address table for the six-read sequence, registered output
module nvsc_seq_rom
  import nvsc_pkg::*;
(
  // clock
  input  wire logic                       clk_i,
  // lookup
  input  wire logic [2:0]                 idx_i,
  input  wire logic [`NVSC_ADDR_W*6-1:0]  table_i,
  output logic      [`NVSC_ADDR_W-1:0]    addr_o
);
  logic [`NVSC_ADDR_W-1:0] addr_q;

  // table comes from the top parameter; order is left to the system
  always_ff @(posedge clk_i) begin
    addr_q <= table_i[idx_i*`NVSC_ADDR_W +: `NVSC_ADDR_W];
  end
  assign addr_o = addr_q;
endmodule : nvsc_seq_rom
`default_nettype wire

// ===== testbench/nvsc_host_monitor.sv
`timescale 1ns/1ns
`default_nettype none
// pin-level checks of the host side
module nvsc_host_monitor #(
  parameter logic [101:0] SEQ_TABLE = '0
)(
  input wire logic        REF_CLK_I, ARST_N_I, CMD_VALID_I, CMD_READY_O, RSP_VALID_O,
  input wire logic [1:0]  CMD_KIND_I,
  input wire logic [15:0] RSP_RDATA_O,
  input wire logic [16:0] MEM_ADDR_O,
  input wire logic        CHIP_EN_N_O, WRITE_EN_N_O, OUT_EN_N_O, STORE_BUSY_N_OE_O
);
  logic soft_q;
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  // marks a soft command from acceptance to its completion pulse
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I)
    if (!ARST_N_I) soft_q <= 1'b0;
    else if (CMD_VALID_I && CMD_READY_O && CMD_KIND_I == 2'h2) soft_q <= 1'b1;
    else if (RSP_VALID_O) soft_q <= 1'b0;
  property p_busy_free; !CHIP_EN_N_O |-> !STORE_BUSY_N_OE_O; endproperty
  a_busy_free: assert property (p_busy_free) else $error("save pulled in access");
  property p_soft_rd;
    CMD_VALID_I && CMD_READY_O && CMD_KIND_I == 2'h2 |-> ##2 !CHIP_EN_N_O && !OUT_EN_N_O;
  endproperty
  a_soft_rd: assert property (p_soft_rd) else $error("soft read not framed");
  property p_soft_adr;
    CMD_VALID_I && CMD_READY_O && CMD_KIND_I == 2'h2 |-> ##2 MEM_ADDR_O == SEQ_TABLE[16:0];
  endproperty
  a_soft_adr: assert property (p_soft_adr) else $error("first address wrong");
  property p_soft_we; soft_q |-> WRITE_EN_N_O; endproperty
  a_soft_we: assert property (p_soft_we) else $error("write during soft");
  property p_soft_dat; soft_q && RSP_VALID_O |-> RSP_RDATA_O == 16'h0000; endproperty
  a_soft_dat: assert property (p_soft_dat) else $error("sixth data kept");
  property p_hw_pulse;
    $rose(STORE_BUSY_N_OE_O) |-> STORE_BUSY_N_OE_O [*4] ##1 !STORE_BUSY_N_OE_O;
  endproperty
  a_hw_pulse: assert property (p_hw_pulse) else $error("save pulse length wrong");
endmodule : nvsc_host_monitor
bind nvsc_host nvsc_host_monitor #(.SEQ_TABLE(SEQ_TABLE)) u_mon (.REF_CLK_I(REF_CLK_I),
  .ARST_N_I(ARST_N_I), .CMD_VALID_I(CMD_VALID_I), .CMD_READY_O(CMD_READY_O),
  .RSP_VALID_O(RSP_VALID_O), .CMD_KIND_I(CMD_KIND_I), .RSP_RDATA_O(RSP_RDATA_O),
  .MEM_ADDR_O(MEM_ADDR_O), .CHIP_EN_N_O(CHIP_EN_N_O), .WRITE_EN_N_O(WRITE_EN_N_O),
  .OUT_EN_N_O(OUT_EN_N_O), .STORE_BUSY_N_OE_O(STORE_BUSY_N_OE_O));
`default_nettype wire

// ===== testbench/nvsc_mem_model.sv
`timescale 1ns/1ns
`default_nettype none
// behavioural memory device with save lockout
module nvsc_mem_model #(
  parameter logic [101:0] SEQ = '0
)(
  input  wire logic        clk_i, ce_n_i, we_n_i, oe_n_i, ub_n_i, lb_n_i, wide_i, hsb_i,
  input  wire logic [16:0] addr_i,
  input  wire logic [15:0] dq_i,
  output logic             hsb_n_o,
  output logic [15:0]      dq_o
);
  logic [15:0] mem [logic [16:0]];
  logic [15:0] last_q = 16'h0000;
  logic [15:0] lm;
  logic        ce_q = 1'b1, we_q = 1'b1, hsb_q = 1'b1, dirty = 1'b0, inh;
  int          step = 0, busy = 0, pend = 0, grace = 0;
  assign lm      = wide_i ? {{8{!ub_n_i}}, {8{!lb_n_i}}} : 16'h00FF;
  assign inh     = busy > 0 || !hsb_i;
  assign hsb_n_o = busy == 0;
  // lanes not driven toggle every cycle
  always_comb begin
    dq_o = ~last_q;
    if (!ce_n_i && we_n_i && !oe_n_i && !inh && step != 5)
      dq_o = (mem.exists(addr_i) ? mem[addr_i] : 16'h0000) & lm | ~last_q & ~lm;
  end
  always @(posedge clk_i) begin
    last_q <= dq_o;
    ce_q   <= ce_n_i;
    we_q   <= we_n_i;
    hsb_q  <= hsb_i;
    if (busy > 0) busy <= busy - 1;
    if (grace > 0) grace <= grace - 1;
    // writes stay open briefly after a save request so one in flight lands
    if (hsb_q && !hsb_i) grace <= 7;
    if (pend > 0) pend <= pend - 1;
    if (pend == 1) busy <= 50;
    if (!ce_n_i && !we_n_i && (!inh || grace > 0)) begin
      mem[addr_i] = dq_i & lm | mem[addr_i] & ~lm;
      dirty <= 1'b1;
    end
    // a save with nothing written is skipped
    if (hsb_q && !hsb_i && dirty) begin
      busy  <= 30;
      dirty <= 1'b0;
    end
    // write enable rises with chip enable, so look at its previous level
    if (ce_n_i && !ce_q && !we_q) step <= 0;
    else if (ce_n_i && !ce_q) begin
      if (addr_i == SEQ[step*17 +: 17]) step <= (step == 5) ? 0 : step + 1;
      else step <= (addr_i == SEQ[16:0]) ? 1 : 0;
      if (step == 5 && addr_i == SEQ[85 +: 17]) pend <= 5;
    end
  end
endmodule : nvsc_mem_model
`default_nettype wire

// ===== testbench/nvsc_host_bench.sv
`timescale 1ns/1ns
`default_nettype none
module nvsc_host_bench;
  localparam logic [101:0] SEQ = {17'h0E38, 17'h01C7, 17'h0FC0, 17'h103F, 17'h08B4, 17'h1A4A};
  logic        clk = 1'b0, arst_n = 1'b0, valid = 1'b0, wide = 1'b1;
  logic        ready, rsp, ce_n, we_n, oe_n, ub_n, lb_n, dq_oe, hsb_oe, dev_hsb_n;
  logic [1:0]  kind = 2'h0, lanes = 2'h3;
  logic [16:0] addr = 17'h0, maddr;
  logic [15:0] wdata = 16'h0, rdata, dq_o, dev_dq, rd;
  logic [15:0] ref_m [16];
  int          failures = 0, check_count = 0, cyc;
  wire logic        store_busy_n = !hsb_oe && dev_hsb_n;
  wire logic [15:0] dq  = dq_oe ? dq_o : dev_dq;
  initial forever #2 clk = ~clk;
  nvsc_host #(.SEQ_TABLE(SEQ), .CYC_SS(20), .CYC_STORE(50)) dut (.REF_CLK_I(clk),
    .ARST_N_I(arst_n), .CMD_VALID_I(valid), .CMD_KIND_I(kind), .CMD_ADDR_I(addr),
    .CMD_WDATA_I(wdata), .CMD_LANES_I(lanes), .WIDE_MODE_I(wide), .CMD_READY_O(ready),
    .RSP_VALID_O(rsp), .RSP_RDATA_O(rdata), .MEM_ADDR_O(maddr), .CHIP_EN_N_O(ce_n),
    .WRITE_EN_N_O(we_n), .OUT_EN_N_O(oe_n), .UPPER_LANE_ENABLE_N_O(ub_n),
    .LOWER_LANE_ENABLE_N_O(lb_n), .MEM_DQ_I(dq), .MEM_DQ_O(dq_o), .MEM_DQ_OE_O(dq_oe),
    .STORE_BUSY_N_I(store_busy_n), .STORE_BUSY_N_O(), .STORE_BUSY_N_OE_O(hsb_oe));
  nvsc_mem_model #(.SEQ(SEQ)) u_dev (.clk_i(clk), .ce_n_i(ce_n), .we_n_i(we_n),
    .oe_n_i(oe_n), .ub_n_i(ub_n), .lb_n_i(lb_n), .wide_i(wide), .hsb_i(store_busy_n),
    .addr_i(maddr), .dq_i(dq), .hsb_n_o(dev_hsb_n), .dq_o(dev_dq));
  function automatic logic [15:0] lmask(input logic [1:0] l, input logic w);
    return w ? {{8{l[1]}}, {8{l[0]}}} : 16'h00FF;
  endfunction : lmask
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    check_count++;
    if (g !== e) begin
      failures++;
      $display("unexpected at %0t: expected %h got %h", $time, e, g);
    end
  endtask : chk
  // wait for ready, present for one edge, then wait for completion
  task automatic op(input logic [1:0] k, input logic [16:0] a, input logic [15:0] d);
    cyc = 0;
    while (ready !== 1'b1 && cyc < 100) begin @(negedge clk); cyc++; end
    if (ready !== 1'b1) failures++;
    kind = k; addr = a; wdata = d; valid = 1'b1;
    @(negedge clk);
    valid = 1'b0;
    cyc = 0;
    while (rsp !== 1'b1 && cyc < 5000) begin @(negedge clk); cyc++; end
    if (rsp !== 1'b1) failures++;
    rd = rdata;
  endtask : op
  task automatic wr(input logic [16:0] a, input logic [15:0] d);
    op(2'h1, a, d);
    ref_m[a[3:0]] = d & lmask(lanes, wide) | ref_m[a[3:0]] & ~lmask(lanes, wide);
  endtask : wr
  task automatic rchk(input logic [16:0] a);
    op(2'h0, a, 16'h0000);
    chk(ref_m[a[3:0]] & lmask(lanes, wide), rd & lmask(lanes, wide));
  endtask : rchk
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // cut a hang short well beyond the expected run length
  initial begin
    repeat (8000) @(posedge clk);
    failures++;
    print_verdict;
  end
  initial begin
    void'($urandom(32'h513FAD48));
    repeat (20) @(posedge clk);
    @(negedge clk);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    for (int i = 0; i < 16; i++) wr(17'(i), 16'($urandom));
    lanes = 2'h1;
    wr(17'h3, 16'hA5C3);
    lanes = 2'h2;
    wr(17'h3, 16'h5A3C);
    lanes = 2'h3;
    rchk(17'h3);
    for (int i = 0; i < 60; i++) begin
      wide  = ($urandom % 4) != 0;
      lanes = 2'($urandom % 3 + 1);
      if ($urandom % 2) wr(17'($urandom % 16), 16'($urandom));
      else rchk(17'($urandom % 16));
    end
    wide = 1'b1;
    lanes = 2'h3;
    op(2'h2, 17'h0, 16'h0000);
    chk(16'h0000, rd);
    rchk(17'h5);
    wr(17'h7, 16'h3C5A);
    op(2'h3, 17'h0, 16'h0000);
    chk(16'h0001, {15'h0, cyc > 30});
    op(2'h3, 17'h0, 16'h0000);
    chk(16'h0001, {15'h0, cyc < 30});
    rchk(17'h7);
    print_verdict;
  end
endmodule : nvsc_host_bench
`default_nettype wire
